//--- design/cbr_pkg.sv
`default_nettype none
package cbr_pkg;
   // ----------------------------------------------------------------
   // Operating modes and status word layout
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      CBR_MODE_USR = 5'h10,
      CBR_MODE_FIQ = 5'h11,
      CBR_MODE_IRQ = 5'h12,
      CBR_MODE_SVC = 5'h13,
      CBR_MODE_ABT = 5'h17,
      CBR_MODE_UND = 5'h1B,
      CBR_MODE_SYS = 5'h1F
   } cbr_mode_e;

   typedef enum logic [1:0] {
      CBR_SIZE_BYTE = 2'h0,
      CBR_SIZE_HALF = 2'h1,
      CBR_SIZE_WORD = 2'h2
   } cbr_size_e;

   localparam int CBR_MODE_LSB = 0;
   localparam int CBR_T_BIT = 5;
   localparam int CBR_F_BIT = 6;
   localparam int CBR_I_BIT = 7;
   localparam int CBR_FLAG_LSB = 28;
   localparam logic [31:0] CBR_USER_WR_MASK = 32'hF000_0000;
   localparam logic [31:0] CBR_PRIV_WR_MASK = 32'hF000_00DF;
   localparam logic [31:0] CBR_STATUS_RESET = 32'h0000_00D3;
   localparam logic [31:0] CBR_RESET_VECTOR = 32'h0000_0000;

   // Physical file: R0-R7, R8-R12 user and fast, then R13/R14 pairs
   localparam int CBR_NUM_GPR = 31;
   localparam int CBR_NUM_BANK = 30;
   localparam int CBR_NUM_SAVED = 5;
   localparam int CBR_NUM_STATUS = 6;
   localparam logic [4:0] CBR_P_HI_USR = 5'h08;
   localparam logic [4:0] CBR_P_HI_FIQ = 5'h0D;
   localparam logic [4:0] CBR_P_SP_USR = 5'h12;
   localparam logic [4:0] CBR_P_SP_FIQ = 5'h14;
   localparam logic [4:0] CBR_P_SP_IRQ = 5'h16;
   localparam logic [4:0] CBR_P_SP_SVC = 5'h18;
   localparam logic [4:0] CBR_P_SP_ABT = 5'h1A;
   localparam logic [4:0] CBR_P_SP_UND = 5'h1C;
   localparam logic [3:0] CBR_IDX_SP = 4'hD;
   localparam logic [3:0] CBR_IDX_LR = 4'hE;
   localparam logic [3:0] CBR_IDX_PC = 4'hF;
   localparam logic [31:0] CBR_STEP_WIDE = 32'h0000_0004;
   localparam logic [31:0] CBR_STEP_COMPACT = 32'h0000_0002;

   // ----------------------------------------------------------------
   // Carried groups and module state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      cbr_mode_e mode;
      logic [31:0] vector;
      logic [3:0] link_ofs;
   } cbr_exc_s;

   typedef struct packed {
      logic [CBR_NUM_BANK-1:0][31:0] gpr;
      logic [31:0] pc;
      logic [31:0] status;
      logic [CBR_NUM_SAVED-1:0][31:0] saved;
      logic [31:0] rd_a;
      logic [31:0] rd_b;
      logic [31:0] instr;
      logic [31:0] lane_wdata;
      logic [3:0] lane_be;
      logic [31:0] load_data;
      logic misalign;
   } cbr_state_s;

   // Legal mode codes only; anything else is refused by the status write
   function automatic logic cbr_mode_ok(input logic [4:0] m);
      return m inside {CBR_MODE_USR, CBR_MODE_FIQ, CBR_MODE_IRQ, CBR_MODE_SVC,
                       CBR_MODE_ABT, CBR_MODE_UND, CBR_MODE_SYS};
   endfunction : cbr_mode_ok

   // Index of the saved status word for a mode; 7 means none
   function automatic logic [2:0] cbr_saved_idx(input logic [4:0] m);
      case (m)
         CBR_MODE_FIQ: return 3'h0;
         CBR_MODE_IRQ: return 3'h1;
         CBR_MODE_SVC: return 3'h2;
         CBR_MODE_ABT: return 3'h3;
         CBR_MODE_UND: return 3'h4;
         default: return 3'h7;
      endcase
   endfunction : cbr_saved_idx
endpackage : cbr_pkg
`default_nettype wire

//--- design/cbr_banked_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_banked_regs #(
   parameter int XLEN = 32 // Datapath width
) (
   input wire logic mclk, // 100 MHz clock
   input wire logic reset_n, // Async reset, active low
   input wire logic big_endian, // Byte order select
   input wire logic [3:0] rd_a_idx, // Read port A index
   input wire logic [3:0] rd_b_idx, // Read port B index
   output logic [31:0] rd_a_data, // Port A data, one cycle later
   output logic [31:0] rd_b_data, // Port B data, one cycle later
   input wire logic wr_en, // General register write
   input wire logic [3:0] wr_idx, // Write index
   input wire logic [31:0] wr_data, // Write data
   input wire logic pc_step, // Advance PC by one instruction
   input wire logic pc_load, // Load PC from pc_target
   input wire logic [31:0] pc_target, // Branch target
   input wire logic branch_link_instr, // Branch with link, target pc_target
   input wire logic branch_exchange_instr, // Branch exchange
   input wire logic [31:0] bx_operand, // Operand register value
   input wire cbr_pkg::cbr_exc_s exc_in, // Exception entry request
   input wire logic exc_return, // Return from exception
   input wire logic [31:0] ret_addr, // Resume address
   input wire logic status_wr_en, // Current status word write
   input wire logic saved_wr_en, // Saved status word write
   input wire logic [31:0] status_wr_data, // Status write data
   input wire logic [31:0] fetch_word, // Fetched memory word
   input wire logic [1:0] mem_addr_lo, // Data address low bits
   input wire cbr_pkg::cbr_size_e mem_size, // Data access size
   input wire logic [31:0] store_data, // Store data, right aligned
   input wire logic [31:0] lane_rdata, // Load data on bus lanes
   output logic [31:0] instr_out, // Instruction, halfword zero-extended
   output logic [31:0] lane_wdata, // Store data on bus lanes
   output logic [3:0] lane_be, // Byte lane enables
   output logic [31:0] load_data, // Load data, right aligned
   output logic misalign, // Access misaligned
   output logic [31:0] pc_out, // R15 view
   output logic [31:0] current_status_word, // Current status word
   output logic [31:0] saved_status_word, // Saved word of active mode
   output logic [4:0] mode_out, // Active mode code
   output logic privileged, // Mode is not user
   output logic state_indicator_signal // High in compact state
);
   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (XLEN != 32) begin : g_bad_xlen
      $error("cbr_banked_regs supports only a 32-bit datapath");
   end

   // ----------------------------------------------------------------
   // State and derived views
   // ----------------------------------------------------------------
   cbr_pkg::cbr_state_s state_reg;
   cbr_pkg::cbr_state_s state_next;
   logic [4:0] mode; // Active mode
   logic compact; // Compact state
   logic [2:0] sidx; // Saved word slot of active mode
   logic [31:0] pc_view; // PC with forced low bits
   logic [31:0] step; // One instruction length

   // Map architectural index and mode to a physical slot
   function automatic logic [4:0] phys(input logic [3:0] idx, input logic [4:0] m);
      logic [4:0] sp_base;
      sp_base = cbr_pkg::CBR_P_SP_USR;
      unique case (m)
         cbr_pkg::CBR_MODE_FIQ: sp_base = cbr_pkg::CBR_P_SP_FIQ;
         cbr_pkg::CBR_MODE_IRQ: sp_base = cbr_pkg::CBR_P_SP_IRQ;
         cbr_pkg::CBR_MODE_SVC: sp_base = cbr_pkg::CBR_P_SP_SVC;
         cbr_pkg::CBR_MODE_ABT: sp_base = cbr_pkg::CBR_P_SP_ABT;
         cbr_pkg::CBR_MODE_UND: sp_base = cbr_pkg::CBR_P_SP_UND;
         default: sp_base = cbr_pkg::CBR_P_SP_USR;
      endcase
      if (idx < 4'h8) begin
         return {1'b0, idx};
      end else if (idx < cbr_pkg::CBR_IDX_SP) begin
         if (m == cbr_pkg::CBR_MODE_FIQ) begin
            return cbr_pkg::CBR_P_HI_FIQ + 5'(idx - 4'h8);
         end
         return cbr_pkg::CBR_P_HI_USR + 5'(idx - 4'h8);
      end else begin
         return sp_base + 5'(idx - cbr_pkg::CBR_IDX_SP);
      end
   endfunction : phys

   // Mode and state bits straight out of the current status word
   assign mode = state_reg.status[cbr_pkg::CBR_MODE_LSB +: 5];
   assign compact = state_reg.status[cbr_pkg::CBR_T_BIT];
   assign sidx = cbr_pkg::cbr_saved_idx(mode);
   assign step = compact ? cbr_pkg::CBR_STEP_COMPACT : cbr_pkg::CBR_STEP_WIDE;

   // PC low bits are forced so a stray odd address is never seen
   assign pc_view = compact ? {state_reg.pc[31:1], 1'b0}
                            : {state_reg.pc[31:2], 2'b00};

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Events by priority: exception entry, exception return, branch
   // exchange, branch with link, load, step. Datapath write goes first
   // so an event in the same cycle overrides it.
   always_comb begin
      logic [31:0] rd;
      logic [1:0] lane;
      logic [4:0] wp;
      logic [4:0] lp;
      logic [2:0] xs;
      logic [31:0] wmask;
      rd = 32'h0000_0000;
      lane = 2'b00;
      wp = 5'h00;
      lp = 5'h00;
      xs = 3'h0;
      wmask = 32'h0000_0000;
      state_next = state_reg;

      // Register read through the bank map of the active mode
      rd = (rd_a_idx == cbr_pkg::CBR_IDX_PC) ? pc_view
           : state_reg.gpr[phys(rd_a_idx, mode)];
      state_next.rd_a = rd;
      rd = (rd_b_idx == cbr_pkg::CBR_IDX_PC) ? pc_view
           : state_reg.gpr[phys(rd_b_idx, mode)];
      state_next.rd_b = rd;

      // Datapath write; R15 writes reload the PC
      if (wr_en) begin
         if (wr_idx == cbr_pkg::CBR_IDX_PC) begin
            state_next.pc = wr_data;
         end else begin
            wp = phys(wr_idx, mode);
            state_next.gpr[wp] = wr_data;
         end
      end

      // Status word writes; user mode may change the flags only
      wmask = (mode == cbr_pkg::CBR_MODE_USR) ? cbr_pkg::CBR_USER_WR_MASK
                                              : cbr_pkg::CBR_PRIV_WR_MASK;
      if (!cbr_pkg::cbr_mode_ok(status_wr_data[cbr_pkg::CBR_MODE_LSB +: 5])) begin
         wmask = cbr_pkg::CBR_USER_WR_MASK;
      end
      if (status_wr_en) begin
         state_next.status = (state_reg.status & ~wmask) | (status_wr_data & wmask);
      end
      if (saved_wr_en && sidx != 3'h7) begin
         state_next.saved[sidx] = status_wr_data;
      end

      // Program counter and state changes
      if (exc_in.valid) begin
         // Entry overrides a status write landing in the same cycle
         state_next.status = state_reg.status;
         xs = cbr_pkg::cbr_saved_idx(exc_in.mode);
         lp = phys(cbr_pkg::CBR_IDX_LR, exc_in.mode);
         state_next.gpr[lp] = state_reg.pc + 32'(exc_in.link_ofs);
         if (xs != 3'h7) begin
            state_next.saved[xs] = state_reg.status;
         end
         state_next.status[cbr_pkg::CBR_MODE_LSB +: 5] = exc_in.mode;
         state_next.status[cbr_pkg::CBR_T_BIT] = 1'b0;
         state_next.status[cbr_pkg::CBR_I_BIT] = 1'b1;
         if (exc_in.mode == cbr_pkg::CBR_MODE_FIQ) begin
            state_next.status[cbr_pkg::CBR_F_BIT] = 1'b1;
         end
         state_next.pc = exc_in.vector;
      end else if (exc_return) begin
         if (sidx != 3'h7) begin
            state_next.status = state_reg.saved[sidx];
         end
         state_next.pc = ret_addr;
      end else if (branch_exchange_instr) begin
         // Only the state bit moves; mode and registers stay as they are
         state_next.status = state_reg.status;
         state_next.status[cbr_pkg::CBR_T_BIT] = bx_operand[0];
         state_next.pc = {bx_operand[31:1], 1'b0};
      end else if (branch_link_instr) begin
         lp = phys(cbr_pkg::CBR_IDX_LR, mode);
         state_next.gpr[lp] = state_reg.pc + step;
         state_next.pc = pc_target;
      end else if (pc_load) begin
         state_next.pc = pc_target;
      end else if (pc_step) begin
         state_next.pc = state_reg.pc + step;
      end

      // Instruction select: whole word or the halfword PC bit 1 names
      if (!compact) begin
         state_next.instr = fetch_word;
      end else if (state_reg.pc[1] ^ big_endian) begin
         state_next.instr = {16'h0000, fetch_word[31:16]};
      end else begin
         state_next.instr = {16'h0000, fetch_word[15:0]};
      end

      // Byte lane steering; big-endian mirrors the lane order
      lane = big_endian ? 2'(2'h3 - mem_addr_lo) : mem_addr_lo;
      if (mem_size == cbr_pkg::CBR_SIZE_HALF) begin
         lane = big_endian ? 2'({mem_addr_lo[1], 1'b0} ^ 2'h2)
                           : {mem_addr_lo[1], 1'b0};
      end
      unique case (mem_size)
         cbr_pkg::CBR_SIZE_BYTE: begin
            state_next.lane_wdata = {4{store_data[7:0]}};
            state_next.lane_be = 4'(4'h1 << lane);
            state_next.load_data = {24'h00_0000, 8'(lane_rdata >> {lane, 3'b000})};
            state_next.misalign = 1'b0;
         end
         cbr_pkg::CBR_SIZE_HALF: begin
            state_next.lane_wdata = {2{store_data[15:0]}};
            state_next.lane_be = 4'(4'h3 << lane);
            state_next.load_data = {16'h0000, 16'(lane_rdata >> {lane, 3'b000})};
            state_next.misalign = mem_addr_lo[0];
         end
         default: begin
            state_next.lane_wdata = store_data;
            state_next.lane_be = 4'hF;
            state_next.load_data = lane_rdata;
            state_next.misalign = (mem_addr_lo != 2'b00);
         end
      endcase
      // Misaligned accesses are flagged and drive no lanes
      if (state_next.misalign) begin
         state_next.lane_be = 4'h0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Reset behaves as an exception into supervisor, wide state
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
         state_reg.status <= cbr_pkg::CBR_STATUS_RESET;
         state_reg.pc <= cbr_pkg::CBR_RESET_VECTOR;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rd_a_data = state_reg.rd_a;
   assign rd_b_data = state_reg.rd_b;
   assign instr_out = state_reg.instr;
   assign lane_wdata = state_reg.lane_wdata;
   assign lane_be = state_reg.lane_be;
   assign load_data = state_reg.load_data;
   assign misalign = state_reg.misalign;
   assign pc_out = pc_view;
   assign current_status_word = state_reg.status;
   assign saved_status_word = (sidx == 3'h7) ? 32'h0000_0000 : state_reg.saved[sidx];
   assign mode_out = mode;
   assign privileged = (mode != cbr_pkg::CBR_MODE_USR);
   assign state_indicator_signal = compact;
endmodule : cbr_banked_regs
`default_nettype wire

//--- test/cbr_banked_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port checks of the banked register block
// ----------------------------------------------------------------
module cbr_banked_regs_sva (
   input wire logic mclk, // Clock
   input wire logic reset_n, // Async reset, active low
   input wire logic big_endian, // Byte order
   input wire logic [1:0] mem_addr_lo, // Data address low bits
   input wire cbr_pkg::cbr_size_e mem_size, // Access size
   input wire logic [31:0] store_data, // Store data
   input wire logic [3:0] lane_be, // Lane enables
   input wire logic [31:0] lane_wdata, // Lane data
   input wire logic misalign, // Misaligned flag
   input wire logic pc_step, // PC advance
   input wire logic pc_load, // PC load
   input wire logic branch_link_instr, // Branch with link
   input wire logic branch_exchange_instr, // Branch exchange
   input wire logic [31:0] bx_operand, // Exchange operand
   input wire cbr_pkg::cbr_exc_s exc_in, // Exception entry
   input wire logic exc_return, // Exception return
   input wire logic wr_en, // Register write
   input wire logic [3:0] wr_idx, // Write index
   input wire logic [31:0] pc_out, // PC view
   input wire logic [31:0] current_status_word, // Status word
   input wire logic [4:0] mode_out, // Mode code
   input wire logic privileged, // Non-user mode
   input wire logic state_indicator_signal // Compact state
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // Events that win priority; a lower one beside them is ignored
   sequence s_bx;
      branch_exchange_instr && !exc_in.valid && !exc_return;
   endsequence
   sequence s_step;
      pc_step && !pc_load && !branch_link_instr && !branch_exchange_instr && !exc_in.valid
         && !exc_return && !(wr_en && wr_idx == 4'hF);
   endsequence
   property p_pc_align;
      pc_out[0] == 1'b0 && (state_indicator_signal || pc_out[1] == 1'b0);
   endproperty
   a_pc_align: assert property (p_pc_align) else $error("pc view misaligned");
   property p_priv;
      privileged == (mode_out != 5'h10) && mode_out == current_status_word[4:0];
   endproperty
   a_priv: assert property (p_priv) else $error("mode or privilege wrong");
   property p_mode_legal;
      mode_out inside {5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F};
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("illegal mode code");
   property p_state_indicator_signal;
      state_indicator_signal == current_status_word[5];
   endproperty
   a_state_indicator_signal: assert property (p_state_indicator_signal) else $error("state signal differs from status");
   // Without branch exchange, exception entry or return the state bit holds
   property p_t_hold;
      !branch_exchange_instr && !exc_in.valid && !exc_return |=> $stable(state_indicator_signal);
   endproperty
   a_t_hold: assert property (p_t_hold) else $error("state changed without event");
   property p_bx;
      s_bx |=> state_indicator_signal == $past(bx_operand[0]) && mode_out == $past(mode_out)
         && pc_out[31:2] == $past(bx_operand[31:2]);
   endproperty
   a_bx: assert property (p_bx) else $error("branch exchange wrong");
   property p_exc;
      exc_in.valid |=> !state_indicator_signal && mode_out == $past(exc_in.mode)
         && pc_out[31:2] == $past(exc_in.vector[31:2]);
   endproperty
   a_exc: assert property (p_exc) else $error("exception entry wrong");
   property p_step;
      s_step |=> pc_out == $past(pc_out) + (state_indicator_signal ? 32'h0000_0002 : 32'h0000_0004);
   endproperty
   a_step: assert property (p_step) else $error("pc step wrong");
   property p_word;
      mem_size == cbr_pkg::CBR_SIZE_WORD && mem_addr_lo == 2'h0 |=> lane_be == 4'hF && !misalign
         && lane_wdata == $past(store_data);
   endproperty
   a_word: assert property (p_word) else $error("word lanes wrong");
   property p_byte;
      mem_size == cbr_pkg::CBR_SIZE_BYTE |=> lane_be == ($past(big_endian) ?
         4'h8 >> $past(mem_addr_lo) : 4'h1 << $past(mem_addr_lo));
   endproperty
   a_byte: assert property (p_byte) else $error("byte lane wrong");
   property p_half_mis;
      mem_size == cbr_pkg::CBR_SIZE_HALF && mem_addr_lo[0] |=> misalign && lane_be == 4'h0;
   endproperty
   a_half_mis: assert property (p_half_mis) else $error("odd halfword not refused");
endmodule : cbr_banked_regs_sva
bind cbr_banked_regs cbr_banked_regs_sva chk_u (.*);
`default_nettype wire

//--- test/cbr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Memory side: answers fetches and data reads with whole words
// ----------------------------------------------------------------
module cbr_mem_model (
   input wire logic [31:0] pc, // Fetch address
   input wire logic [1:0] addr_lo, // Data address low bits
   input wire logic [3:0] salt, // Pattern select from the bench
   output logic [31:0] fetch_word, // Word holding the fetch address
   output logic [31:0] lane_rdata // Word on the data lanes
);
   // Four byte addresses share one word, so halves differ but index alike
   assign fetch_word = {pc[17:2], ~pc[17:2]};
   // Distinct bytes so a wrong lane choice shows in the load data
   assign lane_rdata = 32'h8844_2211 ^ {8{salt}} ^ {30'h0000_0000, addr_lo};
endmodule : cbr_mem_model
`default_nettype wire

//--- test/cbr_banked_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_banked_regs_tb_top;
   logic mclk, reset_n, big_endian, wr_en, pc_step, pc_load, branch_link_instr, exc_return;
   logic branch_exchange_instr, status_wr_en, saved_wr_en, misalign, privileged;
   logic state_indicator_signal;
   logic [3:0] rd_a_idx, rd_b_idx, wr_idx, lane_be, salt;
   logic [1:0] mem_addr_lo;
   logic [4:0] mode_out, md;
   logic [31:0] rd_a_data, rd_b_data, wr_data, pc_target, bx_operand, ret_addr, status_wr_data;
   logic [31:0] fetch_word, store_data, lane_rdata, instr_out, lane_wdata, load_data, pc_out;
   logic [31:0] current_status_word, saved_status_word, pcm;
   cbr_pkg::cbr_exc_s exc_in;
   cbr_pkg::cbr_size_e mem_size;
   logic [31:0] bank [30];
   logic [4:0] mlist [6] = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F};
   logic t;
   int fails, compares, seed, sz, ln, a;
   bit mis;
   cbr_banked_regs dut_u (.*);
   cbr_mem_model mem_u (.pc(pc_out), .addr_lo(mem_addr_lo), .salt(salt),
      .fetch_word(fetch_word), .lane_rdata(lane_rdata));
   // ----------------------------------------------------------------
   // Clock, watchdog and shared tasks
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Whole run is under three hundred cycles; allow about seventy times that
   initial begin
      #200_000;
      fails++;
      give_verdict();
   end
   task automatic give_verdict();
      if (fails == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic tick();
      @(negedge mclk);
   endtask : tick
   // Model map: architectural index plus mode gives the physical slot
   function automatic int phys(input int m, input int i);
      if (i < 8) return i;
      if (i < 13) return (m == 5'h11) ? i + 5 : i;
      case (m)
         5'h11: return i + 7;
         5'h12: return i + 9;
         5'h13: return i + 11;
         5'h17: return i + 13;
         5'h1B: return i + 15;
         default: return i + 5;
      endcase
   endfunction : phys
   task automatic read_chk(input int i);
      rd_a_idx = i[3:0];
      rd_b_idx = 4'(14 - i);
      tick();
      check("rd_a", rd_a_data, bank[phys(md, i)]);
      check("rd_b", rd_b_data, bank[phys(md, 14 - i)]);
   endtask : read_chk
   task automatic write_reg(input int i, input logic [31:0] d);
      wr_en = 1'b1;
      wr_idx = i[3:0];
      wr_data = d;
      tick();
      bank[phys(md, i)] = d;
   endtask : write_reg
   // Status write keeps both interrupt disables set; user may not leave user
   task automatic set_mode(input logic [4:0] m);
      status_wr_en = 1'b1;
      status_wr_data = {24'h00_0000, 3'b110, m};
      tick();
      status_wr_en = 1'b0;
      if (md != 5'h10) md = m;
      check("mode", mode_out, md);
      check("priv", privileged, md != 5'h10);
   endtask : set_mode
   // One control pulse; its data fields are set by the caller beforehand
   task automatic fire(input int k);
      case (k)
         0: branch_exchange_instr = 1'b1;
         1: exc_in.valid = 1'b1;
         2: exc_return = 1'b1;
         3: branch_link_instr = 1'b1;
         4: pc_step = 1'b1;
         default: pc_load = 1'b1;
      endcase
      tick();
      {branch_exchange_instr, exc_in.valid, exc_return} = 3'h0;
      {branch_link_instr, pc_step, pc_load} = 3'h0;
      check("state", state_indicator_signal, t);
      check("pc", pc_out, pcm & (t ? 32'hFFFF_FFFE : 32'hFFFF_FFFC));
      check("mode", mode_out, md);
   endtask : fire
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {big_endian, wr_en, pc_step, pc_load, branch_link_instr, exc_return} = 6'h00;
      {branch_exchange_instr, status_wr_en, saved_wr_en, reset_n} = 4'h0;
      {rd_a_idx, rd_b_idx, wr_idx, salt, mem_addr_lo} = 18'h0_0000;
      {wr_data, pc_target, bx_operand, ret_addr, status_wr_data, store_data} = '0;
      exc_in = '0;
      mem_size = cbr_pkg::CBR_SIZE_BYTE;
      seed = 32'h6bd9_b0ea;
      foreach (bank[i]) bank[i] = 32'h0000_0000;
      {md, t, pcm} = {5'h13, 1'b0, 32'h0000_0000};
      repeat (12) @(posedge mclk);
      tick();
      reset_n = 1'b1;
      check("status", current_status_word, 32'h0000_00D3);
      // Every bank written, then read back in every mode except user
      foreach (mlist[k]) begin
         set_mode(mlist[k]);
         for (int i = 0; i < 15; i++) write_reg(i, $random(seed));
         wr_en = 1'b0;
      end
      foreach (mlist[k]) begin
         set_mode(mlist[k]);
         for (int i = 0; i < 15; i++) read_chk(i);
      end
      // Into compact, step, trap, return, back to wide, then link
      set_mode(5'h13);
      bx_operand = 32'h0000_0101;
      {t, pcm} = {1'b1, 32'h0000_0100};
      fire(0);
      read_chk(13);
      tick();
      check("instr", instr_out, {16'h0000, fetch_word[15:0]});
      pcm = 32'h0000_0102;
      fire(4);
      tick();
      check("instr", instr_out, {16'h0000, fetch_word[31:16]});
      exc_in.mode = cbr_pkg::CBR_MODE_IRQ;
      exc_in.vector = 32'h0000_0018;
      exc_in.link_ofs = 4'h4;
      bank[phys(5'h12, 14)] = pcm + 32'h0000_0004;
      {md, t, pcm} = {5'h12, 1'b0, 32'h0000_0018};
      fire(1);
      check("saved", saved_status_word, 32'h0000_00F3);
      read_chk(14);
      ret_addr = 32'h0000_0104;
      {md, t, pcm} = {5'h13, 1'b1, 32'h0000_0104};
      fire(2);
      tick();
      bx_operand = 32'h0000_0200;
      {t, pcm} = {1'b0, 32'h0000_0200};
      fire(0);
      tick();
      check("instr", instr_out, fetch_word);
      pc_target = 32'h0000_0300;
      bank[phys(md, 14)] = pcm + 32'h0000_0004;
      pcm = 32'h0000_0300;
      fire(3);
      read_chk(14);
      // Plain load with stray low bits, then R15 through the read port
      {pc_target, pcm} = {2{32'h0000_0342}};
      fire(5);
      rd_a_idx = 4'hF;
      tick();
      check("rd_pc", rd_a_data, 32'h0000_0340);
      // Saved word of the active privileged mode
      status_wr_data = 32'hA000_00F1;
      saved_wr_en = 1'b1;
      tick();
      saved_wr_en = 1'b0;
      check("saved", saved_status_word, 32'hA000_00F1);
      set_mode(5'h10);
      read_chk(13);
      set_mode(5'h13);
      // Random data lane traffic in both byte orders
      repeat (60) begin
         sz = {$random(seed)} % 3;
         a = {$random(seed)} % 4;
         big_endian = $random(seed);
         store_data = $random(seed);
         salt = $random(seed);
         mem_addr_lo = a[1:0];
         mem_size = cbr_pkg::cbr_size_e'(sz);
         tick();
         ln = (sz == 2) ? 0 : (big_endian ? ((sz == 0) ? 3 : 2) - a : a);
         mis = (sz == 1 && a[0]) || (sz == 2 && a != 0);
         check("be", lane_be, mis ? 4'h0 : ((sz == 0) ? 4'h1 : (sz == 1) ? 4'h3 : 4'hF) << ln);
         check("mis", misalign, mis);
         if (!mis) begin
            check("wdata", lane_wdata, (sz == 0) ? {4{store_data[7:0]}} :
               (sz == 1) ? {2{store_data[15:0]}} : store_data);
            check("load", load_data, (lane_rdata >> (8 * ln)) & ((sz == 0) ? 32'h0000_00FF :
               (sz == 1) ? 32'h0000_FFFF : 32'hFFFF_FFFF));
         end
      end
      give_verdict();
   end
endmodule : cbr_banked_regs_tb_top
`default_nettype wire
